// >>> logic/osc_pkg.sv
package osc_pkg;

   // ---------------------------------------------------------------
   // Bus and register map
   // ---------------------------------------------------------------
   localparam int          APB_ADDR_W    = 12;
   localparam logic [11:0] ADDR_INPUT_LEVEL_CONTROL_STATUS     = 12'h000;
   localparam logic [11:0] ADDR_OUTPUT_LEVEL_CONTROL_STATUS     = 12'h004;
   localparam logic [15:0] REG_RESET     = 16'h0000;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int          FLAG_LSB      = 12;  // Input request flags 15:12
   localparam int          IN_IRQ_EN_BIT = 8;
   localparam int          MODE_LSB      = 0;   // Mode fields 7:0, two bits each
   localparam int          SHORT_BIT     = 15;
   localparam int          CMP_EN_BIT    = 9;
   localparam int          SHORT_IE_BIT  = 8;
   localparam int          NUM_INPUTS    = 4;
   localparam int          NUM_PAIRS     = 3;

   // ---------------------------------------------------------------
   // Detection modes and sampling
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      OSC_MODE_EDGE   = 2'b00,
      OSC_MODE_DIV8   = 2'b01,
      OSC_MODE_DIV16  = 2'b10,
      OSC_MODE_DIV128 = 2'b11
   } osc_mode_type;

   localparam int          LOW_SAMPLES   = 16;
   localparam int          DIV_W         = 7;
   localparam logic [6:0]  DIV8_MASK     = 7'h07;
   localparam logic [6:0]  DIV16_MASK    = 7'h0F;
   localparam logic [6:0]  DIV128_MASK   = 7'h7F;

endpackage

// >>> logic/osc_det_if.sv
`timescale 1ns/1ps
interface osc_det_if;
   // Mode and sampling enables from the control side
   logic [1:0] mode;
   logic       en8;
   logic       en16;
   logic       en128;
   // Synchronised active-low request level
   logic       pin_lvl;
   // One-cycle pulse when the request is accepted
   logic       accept;

   modport ctrl (output mode, output en8, output en16, output en128,
                 output pin_lvl, input accept);
   modport det  (input mode, input en8, input en16, input en128,
                 input pin_lvl, output accept);
endinterface

// >>> logic/osc_detector.sv
`timescale 1ns/1ps
module osc_detector #(
   parameter int SAMPLES = osc_pkg::LOW_SAMPLES
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Control link
   osc_det_if.det   lnk
);
   import osc_pkg::*;

   localparam int CW = $clog2(SAMPLES + 1);

   // ---------------------------------------------------------------
   // Parameter check
   // ---------------------------------------------------------------
   if (SAMPLES < 2) begin : g_chk
      $error("osc_detector: SAMPLES must be at least 2");
   end

   logic          prev_q;
   logic          prev_d;
   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;
   logic          acc_q;
   logic          acc_d;
   logic          samp;

   // ---------------------------------------------------------------
   // Edge and low-level judgement
   // ---------------------------------------------------------------
   // Sample strobe chosen by the mode field
   always_comb begin
      case (lnk.mode)
         OSC_MODE_DIV8:   samp = lnk.en8;
         OSC_MODE_DIV16:  samp = lnk.en16;
         OSC_MODE_DIV128: samp = lnk.en128;
         default:         samp = 1'b0;
      endcase
   end

   // Next state; a high sample restarts the run so no partial run counts
   always_comb begin
      prev_d = lnk.pin_lvl;
      cnt_d  = cnt_q;
      acc_d  = 1'b0;
      if (lnk.mode == OSC_MODE_EDGE) begin
         cnt_d = '0;
         acc_d = prev_q & ~lnk.pin_lvl;
      end else if (samp) begin
         if (lnk.pin_lvl) begin
            cnt_d = '0;
         end else if (cnt_q == CW'(SAMPLES - 1)) begin
            cnt_d = '0;
            acc_d = 1'b1;
         end else begin
            cnt_d = cnt_q + CW'(1);
         end
      end
   end

   // Reset to idle-high so a pin already low at release counts as an edge
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         prev_q <= 1'b1;
         cnt_q  <= '0;
         acc_q  <= 1'b0;
      end else begin
         prev_q <= prev_d;
         cnt_q  <= cnt_d;
         acc_q  <= acc_d;
      end
   end

   assign lnk.accept = acc_q;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   property p_edge_accept;
      @(posedge mclk) disable iff (sys_rst)
      (lnk.mode == OSC_MODE_EDGE && prev_q && !lnk.pin_lvl) |=> lnk.accept;
   endproperty
   a_edge_accept: assert property (p_edge_accept)
      else $error("falling edge not accepted");

   property p_high_rejects;
      @(posedge mclk) disable iff (sys_rst)
      (lnk.mode != OSC_MODE_EDGE && samp && lnk.pin_lvl)
         |=> (cnt_q == '0 && !lnk.accept);
   endproperty
   a_high_rejects: assert property (p_high_rejects)
      else $error("high sample did not restart the low run");

   property p_level_needs_run;
      @(posedge mclk) disable iff (sys_rst)
      (lnk.mode != OSC_MODE_EDGE && $rose(lnk.accept))
         |-> $past(cnt_q) == CW'(SAMPLES - 1);
   endproperty
   a_level_needs_run: assert property (p_level_needs_run)
      else $error("level request accepted without a full low run");

   c_level_accept: cover property (@(posedge mclk) disable iff (sys_rst)
      lnk.mode == OSC_MODE_DIV8 && lnk.accept);
endmodule

// >>> logic/osc_top.sv
`timescale 1ns/1ps
// Overview of operation
// - Each input has its own two-bit mode
// - Mode 00 accepts a falling edge
// - Other modes need sixteen low divided samples
// - One high sample rejects the low run
// - Accepted request puts outputs high impedance
// - Both outputs of a pair low sets short flag
// - Short flag cleared by 0 after reading 1
// - Compare enable makes short flag request shutdown
// - No shutdown from compare without short irq enable
// - Short interrupt and shutdown rise together
// - Short irq enable raises interrupt on flag
// - Already low pair trips on enable
// - Unused output control bits read zero
// - Registers cleared only by power-on reset
// - Input shutdown holds until all flags clear
// - Pairs 3B/3D, 4A/4C, 4B/4D, low over one cycle
// - Input flags set, irq enable, force shutdown
// - Fourth input uses mode bits 7:6
module osc_top #(
   parameter int ADDR_W = osc_pkg::APB_ADDR_W
) (
   // Clock and power-on reset
   input  wire logic              mclk,
   input  wire logic              sys_rst,
   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // Shutdown request pins, active low
   input  wire logic [osc_pkg::NUM_INPUTS-1:0] shutdown_request_inputs_n,
   // Timer output levels, same clock domain
   input  wire logic              timer_out_ch3_b,
   input  wire logic              timer_out_ch3_d,
   input  wire logic              timer_out_ch4_a,
   input  wire logic              timer_out_ch4_b,
   input  wire logic              timer_out_ch4_c,
   input  wire logic              timer_out_ch4_d,
   // Shutdown and interrupt requests
   output logic                   hiz_request,
   output logic                   input_irq,
   output logic                   short_irq
);
   import osc_pkg::*;

   // ---------------------------------------------------------------
   // Parameter check
   // ---------------------------------------------------------------
   if (ADDR_W < 3 || ADDR_W > 32) begin : g_chk
      $error("osc_top: ADDR_W must lie in 3..32");
   end

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   logic [NUM_INPUTS-1:0]   sync1_q;
   logic [NUM_INPUTS-1:0]   sync2_q;
   logic [DIV_W-1:0]        div_q;
   logic [DIV_W-1:0]        div_d;
   logic                    en8;
   logic                    en16;
   logic                    en128;
   logic [NUM_INPUTS-1:0]   accept;
   logic [NUM_INPUTS-1:0]   flag_q;
   logic [NUM_INPUTS-1:0]   flag_d;
   logic [NUM_INPUTS-1:0]   flag_arm_q;
   logic [NUM_INPUTS-1:0]   flag_arm_d;
   logic                    in_ie_q;
   logic                    in_ie_d;
   logic [2*NUM_INPUTS-1:0] mode_q;
   logic [2*NUM_INPUTS-1:0] mode_d;
   logic                    osf_q;
   logic                    osf_d;
   logic                    osf_arm_q;
   logic                    osf_arm_d;
   logic                    oce_q;
   logic                    oce_d;
   logic                    oie_q;
   logic                    oie_d;
   logic [NUM_PAIRS-1:0]    pair_low;
   logic [NUM_PAIRS-1:0]    pair_low_q;
   logic                    short_now;
   logic                    pready_q;
   logic                    pready_d;
   logic [31:0]             prdata_q;
   logic [31:0]             prdata_d;
   logic                    pslverr_q;
   logic                    pslverr_d;
   logic                    hiz_q;
   logic                    hiz_d;
   logic                    in_irq_q;
   logic                    in_irq_d;
   logic                    sh_irq_q;
   logic                    sh_irq_d;
   logic                    sel_input_level_control_status;
   logic                    sel_output_level_control_status;
   logic                    xfer_done;
   logic                    wr_done;
   logic                    rd_done;
   logic [15:0]             input_level_control_status_view;
   logic [15:0]             output_level_control_status_view;

   // ---------------------------------------------------------------
   // Pin synchronisers and sampling divider
   // ---------------------------------------------------------------
   // Second stage alone feeds the detectors
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         sync1_q <= '1;
         sync2_q <= '1;
      end else begin
         sync1_q <= shutdown_request_inputs_n;
         sync2_q <= sync1_q;
      end
   end

   // Free-running divider; one pulse each per 8, 16 and 128 cycles
   always_comb begin
      div_d = div_q + DIV_W'(1);
      en8   = (div_q & DIV8_MASK)   == DIV8_MASK;
      en16  = (div_q & DIV16_MASK)  == DIV16_MASK;
      en128 = (div_q & DIV128_MASK) == DIV128_MASK;
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         div_q <= '0;
      end else begin
         div_q <= div_d;
      end
   end

   // ---------------------------------------------------------------
   // Per-input detectors
   // ---------------------------------------------------------------
   for (genvar i = 0; i < NUM_INPUTS; i++) begin : g_det
      osc_det_if lnk ();
      // Each input reads only its own mode field
      assign lnk.mode    = mode_q[2*i +: 2];
      assign lnk.en8     = en8;
      assign lnk.en16    = en16;
      assign lnk.en128   = en128;
      assign lnk.pin_lvl = sync2_q[i];
      assign accept[i]   = lnk.accept;
      osc_detector #(.SAMPLES(LOW_SAMPLES)) u_det (
         .mclk    (mclk),
         .sys_rst (sys_rst),
         .lnk     (lnk.det)
      );
   end

   // ---------------------------------------------------------------
   // Output level compare
   // ---------------------------------------------------------------
   // A glitch of one cycle is tolerated; two cycles low trips
   always_comb begin
      pair_low[0] = ~timer_out_ch3_b & ~timer_out_ch3_d;
      pair_low[1] = ~timer_out_ch4_a & ~timer_out_ch4_c;
      pair_low[2] = ~timer_out_ch4_b & ~timer_out_ch4_d;
      short_now   = |(pair_low & pair_low_q);
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         pair_low_q <= '0;
      end else begin
         pair_low_q <= pair_low;
      end
   end

   // ---------------------------------------------------------------
   // APB decode
   // ---------------------------------------------------------------
   // One wait state so that every bus output comes from a flop
   always_comb begin
      sel_input_level_control_status  = paddr == ADDR_W'(ADDR_INPUT_LEVEL_CONTROL_STATUS);
      sel_output_level_control_status  = paddr == ADDR_W'(ADDR_OUTPUT_LEVEL_CONTROL_STATUS);
      xfer_done = psel & penable & pready_q;
      wr_done   = xfer_done & pwrite;
      rd_done   = xfer_done & ~pwrite;
      input_level_control_status_view = {flag_q, 3'b000, in_ie_q, mode_q};
      output_level_control_status_view = {osf_q, 5'b0_0000, oce_q, oie_q, 8'h00};
   end

   // ---------------------------------------------------------------
   // Register next state
   // ---------------------------------------------------------------
   always_comb begin
      flag_d     = flag_q;
      flag_arm_d = flag_arm_q;
      in_ie_d    = in_ie_q;
      mode_d     = mode_q;
      osf_d      = osf_q;
      osf_arm_d  = osf_arm_q;
      oce_d      = oce_q;
      oie_d      = oie_q;
      // Reading a flag as 1 arms its clear
      if (rd_done && sel_input_level_control_status) begin
         flag_arm_d = flag_arm_q | flag_q;
      end
      if (rd_done && sel_output_level_control_status) begin
         osf_arm_d = osf_arm_q | osf_q;
      end
      if (wr_done && sel_input_level_control_status) begin
         for (int k = 0; k < NUM_INPUTS; k++) begin
            if (!pwdata[FLAG_LSB+k] && flag_arm_q[k]) begin
               flag_d[k]     = 1'b0;
               flag_arm_d[k] = 1'b0;
            end
         end
         in_ie_d = pwdata[IN_IRQ_EN_BIT];
         mode_d  = pwdata[MODE_LSB +: 2*NUM_INPUTS];
      end
      if (wr_done && sel_output_level_control_status) begin
         // Writing 1 leaves the flag alone
         if (!pwdata[SHORT_BIT] && osf_arm_q) begin
            osf_d     = 1'b0;
            osf_arm_d = 1'b0;
         end
         oce_d = pwdata[CMP_EN_BIT];
         oie_d = pwdata[SHORT_IE_BIT];
      end
      // Hardware sets win over a clear in the same cycle
      flag_d = flag_d | accept;
      if (oce_q && short_now) begin
         osf_d = 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Bus answer and request outputs
   // ---------------------------------------------------------------
   always_comb begin
      pready_d  = psel & penable & ~pready_q;
      prdata_d  = 32'h0000_0000;
      pslverr_d = 1'b0;
      if (pready_d) begin
         pslverr_d = ~(sel_input_level_control_status | sel_output_level_control_status);
         if (!pwrite && sel_input_level_control_status) begin
            prdata_d = {16'h0000, input_level_control_status_view};
         end else if (!pwrite && sel_output_level_control_status) begin
            prdata_d = {16'h0000, output_level_control_status_view};
         end
      end
      // Input flags hold shutdown until every one is cleared
      hiz_d    = (|flag_d)
               | (oce_d & oie_d & osf_d);
      in_irq_d = in_ie_d & (|flag_d);
      sh_irq_d = oie_d & osf_d;
   end

   // Only the power-on reset clears state; no other reset reaches here
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         flag_q     <= REG_RESET[FLAG_LSB +: NUM_INPUTS];
         flag_arm_q <= '0;
         in_ie_q    <= REG_RESET[IN_IRQ_EN_BIT];
         mode_q     <= REG_RESET[MODE_LSB +: 2*NUM_INPUTS];
         osf_q      <= REG_RESET[SHORT_BIT];
         osf_arm_q  <= 1'b0;
         oce_q      <= REG_RESET[CMP_EN_BIT];
         oie_q      <= REG_RESET[SHORT_IE_BIT];
         pready_q   <= 1'b0;
         prdata_q   <= 32'h0000_0000;
         pslverr_q  <= 1'b0;
         hiz_q      <= 1'b0;
         in_irq_q   <= 1'b0;
         sh_irq_q   <= 1'b0;
      end else begin
         flag_q     <= flag_d;
         flag_arm_q <= flag_arm_d;
         in_ie_q    <= in_ie_d;
         mode_q     <= mode_d;
         osf_q      <= osf_d;
         osf_arm_q  <= osf_arm_d;
         oce_q      <= oce_d;
         oie_q      <= oie_d;
         pready_q   <= pready_d;
         prdata_q   <= prdata_d;
         pslverr_q  <= pslverr_d;
         hiz_q      <= hiz_d;
         in_irq_q   <= in_irq_d;
         sh_irq_q   <= sh_irq_d;
      end
   end

   assign prdata      = prdata_q;
   assign pready      = pready_q;
   assign pslverr     = pslverr_q;
   assign hiz_request = hiz_q;
   assign input_irq   = in_irq_q;
   assign short_irq   = sh_irq_q;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   property p_accept_hiz;
      @(posedge mclk) disable iff (sys_rst)
      (|accept) |=> (|flag_q) && hiz_request;
   endproperty
   a_accept_hiz: assert property (p_accept_hiz)
      else $error("accepted request did not force shutdown");

   property p_flags_hold_hiz;
      @(posedge mclk) disable iff (sys_rst)
      (|flag_q) |-> hiz_request;
   endproperty
   a_flags_hold_hiz: assert property (p_flags_hold_hiz)
      else $error("shutdown released while an input flag is set");

   property p_short_sets;
      @(posedge mclk) disable iff (sys_rst)
      (oce_q && (|(pair_low & pair_low_q))) |=> osf_q;
   endproperty
   a_short_sets: assert property (p_short_sets)
      else $error("sustained low pair did not set short flag");

   property p_single_low_ok;
      @(posedge mclk) disable iff (sys_rst)
      (!osf_q && pair_low_q == '0 && !(wr_done && sel_output_level_control_status)) |=> !osf_q;
   endproperty
   a_single_low_ok: assert property (p_single_low_ok)
      else $error("short flag set by a one-cycle low");

   // Compared on registered values, so a same-cycle flag set is not mistaken
   property p_no_oie_no_hiz;
      @(posedge mclk) disable iff (sys_rst)
      !oie_q |-> (hiz_request == (|flag_q));
   endproperty
   a_no_oie_no_hiz: assert property (p_no_oie_no_hiz)
      else $error("compare shutdown without short irq enable");

   property p_irq_with_hiz;
      @(posedge mclk) disable iff (sys_rst)
      (oce_q && oie_q && osf_q) |-> (hiz_request && short_irq);
   endproperty
   a_irq_with_hiz: assert property (p_irq_with_hiz)
      else $error("short interrupt and shutdown not together");

   property p_irq_off;
      @(posedge mclk) disable iff (sys_rst)
      !oie_q |-> !short_irq;
   endproperty
   a_irq_off: assert property (p_irq_off)
      else $error("short interrupt while disabled");

   property p_write1_keeps;
      @(posedge mclk) disable iff (sys_rst)
      (wr_done && sel_output_level_control_status && pwdata[SHORT_BIT] && osf_q) |=> osf_q;
   endproperty
   a_write1_keeps: assert property (p_write1_keeps)
      else $error("writing 1 cleared the short flag");

   property p_reserved_zero;
      @(posedge mclk) disable iff (sys_rst)
      (pready_d && !pwrite && sel_output_level_control_status)
         |=> (prdata[7:0] == 8'h00 && prdata[14:10] == 5'b0_0000);
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("reserved bits read nonzero");

   c_input_hiz: cover property (@(posedge mclk) disable iff (sys_rst)
      $rose(hiz_request) && (|flag_q));
   c_short_trip: cover property (@(posedge mclk) disable iff (sys_rst)
      $rose(osf_q) && oce_q && oie_q);
   c_release: cover property (@(posedge mclk) disable iff (sys_rst)
      $fell(hiz_request));
endmodule

// >>> dv/osc_fault_src.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Fault source driving the shutdown request pins
// ---------------------------------------------------------------
module osc_fault_src (
   // Clock
   input  wire logic       mclk,
   // Bench command: hold a pin low
   input  wire logic [3:0] hold_low,
   // Active-low request pins
   output logic      [3:0] req_n
);
   // Pins idle high, so level detection never starts on a stale low
   initial req_n = 4'hF;
   // Registered, so every edge lands just after a clock edge
   always @(posedge mclk) req_n <= ~hold_low;
endmodule

// >>> dv/osc_top_tb_top.sv
`timescale 1ns/1ps
module osc_top_tb_top;
   import osc_pkg::*;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   logic        mclk, sys_rst, psel, penable, pwrite;
   logic        pready, pslverr, hiz_request, input_irq, short_irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, f;
   logic [31:0] exp_q[$];
   logic [3:0]  hold_low, req_n;
   logic [5:0]  tmr;  // Order 4d,4c,4b,4a,3d,3b
   logic [5:0]  pair_m[3] = '{6'h03, 6'h14, 6'h28};
   int          fail_count, comparisons, seed, div;

   osc_fault_src src_u (.mclk(mclk), .hold_low(hold_low), .req_n(req_n));
   osc_top dut_u (
      .mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .shutdown_request_inputs_n(req_n),
      .timer_out_ch3_b(tmr[0]), .timer_out_ch3_d(tmr[1]), .timer_out_ch4_a(tmr[2]),
      .timer_out_ch4_b(tmr[3]), .timer_out_ch4_c(tmr[4]), .timer_out_ch4_d(tmr[5]),
      .hiz_request(hiz_request), .input_irq(input_irq), .short_irq(short_irq));

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask
   // One APB transfer; an extra edge after release keeps drives apart
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1 && n < 50) begin
         @(posedge mclk);
         n++;
      end
      if (n == 50) fail_count++;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      xfer(1'b0, a, 32'h0000_0000);
   endtask
   // Upper half is random: it must never reach a register
   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      xfer(1'b1, a, {16'($random(seed)), d});
   endtask
   task automatic pin(input int k, input int n);
      hold_low[k] <= 1'b1;
      cyc(n);
      hold_low[k] <= 1'b0;
   endtask
   task automatic end_of_test;
      if (fail_count == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Clock, read monitor and watchdog
   // ---------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   // Each read answer is compared with the oldest note
   // Every answer also carries an error flag for unmapped addresses
   always @(posedge mclk) begin
      if (psel && penable && pready === 1'b1) begin
         chk(pslverr, 32'(paddr != ADDR_INPUT_LEVEL_CONTROL_STATUS && paddr != ADDR_OUTPUT_LEVEL_CONTROL_STATUS));
         if (!pwrite)
            chk(prdata, exp_q.size() ? exp_q.pop_front() : 32'hDEAD_BEEF);
      end
   end
   // Tests need about 7500 cycles; allow more than twice that
   initial begin
      #72000;
      fail_count++;
      end_of_test;
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      sys_rst = 1'b1;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      hold_low = 4'h0;
      tmr = 6'h3F;  // Timer pins are driven outputs before any compare
      seed = 32'h1908;
      fail_count = 0;
      comparisons = 0;
      cyc(16);
      sys_rst <= 1'b0;
      cyc(1);
      rd(ADDR_INPUT_LEVEL_CONTROL_STATUS, 32'h0000_0000);
      rd(ADDR_OUTPUT_LEVEL_CONTROL_STATUS, 32'h0000_0000);
      rd(12'h008, 32'h0000_0000);
      wr(ADDR_OUTPUT_LEVEL_CONTROL_STATUS, 16'hFFFF);
      rd(ADDR_OUTPUT_LEVEL_CONTROL_STATUS, 32'h0000_0300);
      wr(ADDR_OUTPUT_LEVEL_CONTROL_STATUS, 16'h0000);
      // Falling edge on input 0 latches until cleared
      wr(ADDR_INPUT_LEVEL_CONTROL_STATUS, 16'h0100);
      pin(0, 3);
      cyc(8);
      chk(hiz_request, 1'b1);
      chk(input_irq, 1'b1);
      rd(ADDR_INPUT_LEVEL_CONTROL_STATUS, 32'h0000_1100);
      wr(ADDR_INPUT_LEVEL_CONTROL_STATUS, 16'h0100);
      rd(ADDR_INPUT_LEVEL_CONTROL_STATUS, 32'h0000_0100);
      chk(hiz_request, 1'b0);
      chk(input_irq, 1'b0);
      // Level modes /8, /16, /128 on inputs 1..3: short run refused, long accepted
      wr(ADDR_INPUT_LEVEL_CONTROL_STATUS, 16'h01E4);
      f = 32'h0000_01E4;
      for (int k = 1; k < 4; k++) begin
         div = (k == 1) ? 8 : (k == 2) ? 16 : 128;
         // Two short runs split by a high sample must not add up
         repeat (2) begin
            pin(k, 14 * div);
            cyc(div + 4);
         end
         rd(ADDR_INPUT_LEVEL_CONTROL_STATUS, f);
         pin(k, 17 * div + 8);
         cyc(4);
         f = f | (32'h1 << (12 + k));
         rd(ADDR_INPUT_LEVEL_CONTROL_STATUS, f);
      end
      chk(hiz_request, 1'b1);
      wr(ADDR_INPUT_LEVEL_CONTROL_STATUS, 16'h01E4);
      rd(ADDR_INPUT_LEVEL_CONTROL_STATUS, 32'h0000_01E4);
      wr(ADDR_INPUT_LEVEL_CONTROL_STATUS, 16'h0000);
      // A one-cycle low on a pair is not a short
      wr(ADDR_OUTPUT_LEVEL_CONTROL_STATUS, 16'h0200);
      tmr <= ~pair_m[0];
      cyc(1);
      tmr <= 6'h3F;
      cyc(4);
      rd(ADDR_OUTPUT_LEVEL_CONTROL_STATUS, 32'h0000_0200);
      // Each pair shorted with shutdown masked; clear needs a read of 1
      for (int p = 0; p < 3; p++) begin
         wr(ADDR_OUTPUT_LEVEL_CONTROL_STATUS, 16'h0200);
         tmr <= ~pair_m[p];
         cyc(6);
         chk(hiz_request, 1'b0);
         wr(ADDR_OUTPUT_LEVEL_CONTROL_STATUS, 16'h0000);
         tmr <= 6'h3F;
         rd(ADDR_OUTPUT_LEVEL_CONTROL_STATUS, 32'h0000_8000);
         wr(ADDR_OUTPUT_LEVEL_CONTROL_STATUS, 16'h0000);
         rd(ADDR_OUTPUT_LEVEL_CONTROL_STATUS, 32'h0000_0000);
      end
      // Pair already low when compare is switched on
      tmr <= ~pair_m[1];
      wr(ADDR_OUTPUT_LEVEL_CONTROL_STATUS, 16'h0300);
      cyc(4);
      chk(hiz_request, 1'b1);
      chk(short_irq, 1'b1);
      rd(ADDR_OUTPUT_LEVEL_CONTROL_STATUS, 32'h0000_8300);
      wr(ADDR_OUTPUT_LEVEL_CONTROL_STATUS, 16'h8100);
      cyc(2);
      chk(hiz_request, 1'b0);
      chk(short_irq, 1'b1);
      tmr <= 6'h3F;  // Compared pins high before the flag is cleared
      wr(ADDR_OUTPUT_LEVEL_CONTROL_STATUS, 16'h0100);
      rd(ADDR_OUTPUT_LEVEL_CONTROL_STATUS, 32'h0000_0100);
      chk(short_irq, 1'b0);
      // A second power-on reset clears the setting
      wr(ADDR_INPUT_LEVEL_CONTROL_STATUS, 16'h0155);
      sys_rst <= 1'b1;
      cyc(2);
      sys_rst <= 1'b0;
      cyc(1);
      rd(ADDR_OUTPUT_LEVEL_CONTROL_STATUS, 32'h0000_0000);
      rd(ADDR_INPUT_LEVEL_CONTROL_STATUS, 32'h0000_0000);
      end_of_test;
   end
endmodule
